// ==== bench/bsctap_tb_top.sv ====
// self-checking bench for the boundary scan port
`timescale 1ns/1ns
module bsctap_tb_top;
    import bsctap_pkg::*;
    localparam int NI = 16; // chain inputs
    localparam int NO = 16; // chain outputs
    localparam logic [31:0] ID_VAL = 32'h3C5A9617; // arbitrary id value, lsb one

    logic clk;
    logic rstn;
    logic test_port_reset_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [NI-1:0] core_in;
    logic [NO-1:0] core_out;
    logic [NO-1:0] pin_out;
    logic test_mode;
    int failures;
    int n_compared;

    // ****************************************
    // clock and instances
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    bsctap_top #(.N_IN(NI), .N_OUT(NO), .ID_CODE(ID_VAL)) uut (
        .clk(clk), .rstn(rstn), .test_port_reset_n(test_port_reset_n),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
        .core_in(core_in), .core_out(core_out), .pin_out(pin_out),
        .test_mode(test_mode)
    );

    bsctap_tester tester (
        .clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi)
    );

    // ****************************************
    // compare and closing
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic check_flag(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask : check_flag

    task automatic test_done();
        if (failures == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ****************************************
    // scenarios
    // ****************************************
    // functional mode and id after reset
    task automatic t_reset_state();
        logic [31:0] d;
        int oe0;
        core_out = 16'h3C96;
        tester.reset_idle();
        check("pin_out", {16'h0, 16'h3C96}, {16'h0, pin_out}); // outputs pass through
        check_flag("test_mode", 1'b0, test_mode); // no test control
        oe0 = tester.oe_hi;
        tester.dr_scan(32, 32'h0, 1'b0, d);
        check("idcode", ID_VAL, d); // id shifted out
        check("tdo_oe count", 32'h20, 32'(tester.oe_hi - oe0)); // driven in shift only
        check_flag("tdo_oe idle", 1'b0, tdo_oe); // released in idle
    endtask : t_reset_state

    // bypass and an unused code, one stage delay
    task automatic t_bypass();
        logic [2:0] cap;
        logic [31:0] d;
        logic [2:0] codes [2];
        codes = '{INSN_BYPASS, 3'h5};
        foreach (codes[k]) begin
            tester.ir_scan(codes[k], cap);
            check("ir capture", {29'h0, IR_CAPTURE}, {29'h0, cap}); // pattern out
            tester.dr_scan(8, 32'h000000B4, 1'b0, d);
            check("bypass", 32'h00000068, {24'h0, d[7:0]}); // one bit delay
        end
    endtask : t_bypass

    // sample records inputs and outputs
    task automatic t_sample();
        logic [2:0] cap;
        logic [31:0] d;
        core_in = 16'h5A3C;
        core_out = 16'h96E1;
        tester.ir_scan(INSN_SAMPLE, cap);
        tester.dr_scan(32, 32'h0, 1'b0, d);
        check("sample chain", {16'h96E1, 16'h5A3C}, d); // pins captured
        check("pin_out sample", {16'h0, 16'h96E1}, {16'h0, pin_out}); // outputs untouched
    endtask : t_sample

    // extest with pause, then tms reset from shift
    task automatic t_extest();
        logic [2:0] cap;
        logic [31:0] d;
        logic q;
        core_in = 16'hC3A5;
        tester.ir_scan(INSN_EXTEST, cap);
        check_flag("test_mode extest", 1'b1, test_mode); // instruction adopted
        tester.dr_scan(32, 32'hA55A0000, 1'b1, d);
        check("extest inputs", {16'h0, 16'hC3A5}, {16'h0, d[15:0]}); // shifted out before pause
        core_out = 16'h0F0F;
        repeat (2) @(negedge clk);
        check("extest outputs", {16'h0, 16'hA55A}, {16'h0, pin_out}); // latch drives
        tester.step(1'b1, 1'b0, q);
        tester.step(1'b0, 1'b0, q);
        tester.step(1'b0, 1'b0, q);
        tester.reset_idle();
        check_flag("test_mode tms reset", 1'b0, test_mode); // back to function
        check("pin_out tms reset", {16'h0, 16'h0F0F}, {16'h0, pin_out}); // outputs freed
        tester.dr_scan(32, 32'h0, 1'b0, d);
        check("id after tms reset", ID_VAL, d); // id reloaded
    endtask : t_extest

    // production test loads id into the chain
    task automatic t_scpt();
        logic [2:0] cap;
        logic [31:0] d;
        tester.ir_scan(INSN_SCPT, cap);
        tester.dr_scan(32, 32'h0, 1'b0, d);
        check("production chain", ID_VAL, d); // id captured
    endtask : t_scpt

    // test reset pulled during extest
    task automatic t_trst();
        logic [2:0] cap;
        logic [31:0] d;
        logic q;
        tester.ir_scan(INSN_EXTEST, cap);
        test_port_reset_n = 1'b0;
        #1;
        check_flag("test_mode trst", 1'b0, test_mode); // cleared at once
        check_flag("tdo_oe trst", 1'b0, tdo_oe); // tdo released
        repeat (2) @(negedge clk);
        test_port_reset_n = 1'b1;
        repeat (6) @(negedge clk);
        tester.step(1'b0, 1'b0, q);
        tester.dr_scan(32, 32'h0, 1'b0, d);
        check("id after trst", ID_VAL, d); // id instruction back
    endtask : t_trst

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        failures = 0;
        n_compared = 0;
        rstn = 1'b0;
        test_port_reset_n = 1'b1;
        core_in = '0;
        core_out = '0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (6) @(negedge clk);
        t_reset_state();
        t_bypass();
        t_sample();
        t_extest();
        t_scpt();
        t_trst();
        test_done();
    end

    // cuts a hang short well past the expected run
    initial begin
        #300000;
        failures++;
        test_done();
    end
endmodule : bsctap_tb_top

// ==== bench/bsctap_tester.sv ====
// scan controller model driving tck, tms and tdi
`timescale 1ns/1ns
module bsctap_tester
    import bsctap_pkg::*;
(
    input wire logic clk,
    input wire logic tdo,
    input wire logic tdo_oe,
    output logic tck,
    output logic tms,
    output logic tdi
);
    int oe_hi; // samples that saw tdo driven

    // tck parked low outside frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        oe_hi = 0;
    end

    // one tck period: lines set in low phase, tdo read mid high phase
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        repeat (2) @(negedge clk);
        // a released tdo has no keeper, so show it inverted
        q = (tdo_oe === 1'b1) ? tdo : ~tdo;
        if (tdo_oe === 1'b1) begin
            oe_hi++;
        end
        repeat (2) @(negedge clk);
        tck = 1'b0;
    endtask : step

    // between frames tdi carries no data, so it flips
    task automatic park();
        @(negedge clk);
        tdi = ~tdi;
    endtask : park

    task automatic reset_idle();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        park();
    endtask : reset_idle

    task automatic ir_scan(input logic [2:0] insn, output logic [2:0] cap);
        logic q;
        step(1'b1, 1'b0, q);
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < IR_WIDTH; i++) begin
            step(i == IR_WIDTH - 1, insn[i], cap[i]);
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        park();
    endtask : ir_scan

    // data scan from idle, optional pause half way
    task automatic dr_scan(input int n, input logic [31:0] din, input bit pz,
                           output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || (pz && i == n / 2), din[i], dout[i]);
            // exit1, pause twice, exit2, back to shift
            if (pz && i == n / 2) begin
                step(1'b0, 1'b0, q);
                step(1'b0, 1'b0, q);
                step(1'b1, 1'b0, q);
                step(1'b0, 1'b0, q);
            end
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        park();
    endtask : dr_scan
endmodule : bsctap_tester

// ==== hdl/bsctap_fsm.sv ====
// sixteen state scan controller advanced on tck rising edges
`timescale 1ns/1ns
module bsctap_fsm
    import bsctap_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic tck_rise,
    input wire logic tms,
    output bsctap_pkg::bsctap_state_e state
);
    import bsctap_pkg::*;

    bsctap_state_e next_state; // state after this tck edge

    // ****************************************
    // transition graph
    // ****************************************
    always_comb begin
        case (state)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // state register, moves only on tck rise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RESET;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

endmodule : bsctap_fsm

// ==== hdl/bsctap_pkg.sv ====
// package holding the scan port constants, states and carrier types
package bsctap_pkg;

    // ****************************************
    // instruction register
    // ****************************************
    localparam int IR_WIDTH = 3; // instruction width
    localparam logic [2:0] INSN_EXTEST = 3'h0; // external test
    localparam logic [2:0] INSN_IDCODE = 3'h1; // identification
    localparam logic [2:0] INSN_SAMPLE = 3'h2; // sample pins
    localparam logic [2:0] INSN_SCPT = 3'h3; // single chain production test
    localparam logic [2:0] INSN_BYPASS = 3'h7; // bypass
    localparam logic [2:0] IR_CAPTURE = 3'h1; // fixed capture pattern
    localparam logic [2:0] IR_RESET = INSN_IDCODE; // value in reset state

    // ****************************************
    // identification register
    // ****************************************
    localparam int ID_WIDTH = 32; // id register width
    localparam logic [31:0] ID_DEFAULT = 32'h00000001; // arbitrary id value, lsb one

    // ****************************************
    // sizes and counts
    // ****************************************
    localparam int BSR_IN_DEFAULT = 8; // default sampled input count
    localparam int BSR_OUT_DEFAULT = 8; // default driven output count
    localparam int RESET_TMS_CYCLES = 5; // tms high edges to reset
    localparam int SYNC_STAGES = 2; // synchroniser depth

    // ****************************************
    // controller states, one hot
    // ****************************************
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bsctap_state_e;

    // scan pins from the tester
    typedef struct packed {
        logic tck; // test clock
        logic tms; // mode select
        logic tdi; // data in
    } bsctap_pins_s;

    // clock edge events on the system clock
    typedef struct packed {
        logic rise; // tck rising edge seen
        logic fall; // tck falling edge seen
    } bsctap_edge_s;

endpackage : bsctap_pkg

// ==== hdl/bsctap_sync.sv ====
// two stage synchroniser and tck edge finder for the scan pins
`timescale 1ns/1ns
module bsctap_sync
    import bsctap_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire bsctap_pkg::bsctap_pins_s pins_async,
    output bsctap_pkg::bsctap_pins_s pins,
    output bsctap_pkg::bsctap_edge_s edges
);
    import bsctap_pkg::*;

    // ****************************************
    // synchroniser chain
    // ****************************************
    bsctap_pins_s meta; // first stage, read only by second
    bsctap_pins_s tck_prev; // delayed copy for edge finding
    wire logic rise_w; // rising edge of synced tck
    wire logic fall_w; // falling edge of synced tck

    assign rise_w = pins.tck & ~tck_prev.tck;
    assign fall_w = ~pins.tck & tck_prev.tck;
    assign edges = '{rise: rise_w, fall: fall_w};

    // two flops then one more for history
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            pins <= '0;
            tck_prev <= '0;
        end else begin
            meta <= pins_async;
            pins <= meta;
            tck_prev <= pins;
        end
    end

endmodule : bsctap_sync

// ==== hdl/bsctap_top.sv ====
// boundary scan test access port: controller, instruction and data registers
// How it works
// - controller steps on tck rise, tms steers
// - test reset low forces reset state at once
// - five tms high edges reach reset state
// - reset state holds identification instruction
// - reset state leaves device in functional mode except while a reset is held, which drives outputs low
// - capture-dr loads selected register or keeps
// - shift-dr moves selected register msb to lsb
// - update-dr loads output latch on tck fall
// - capture-ir loads fixed instruction pattern
// - shift-ir moves instruction register msb to lsb
// - update-ir adopts shifted instruction on fall
// - pause states hold register contents
// - each instruction selects one serial path
// - bypass gives one tck period delay
// - boundary chain covers every input and output
// - extest samples inputs and drives outputs
// - sample records inputs and outputs
// - identification register shifts code out
// - production test captures id into chain
`timescale 1ns/1ns
module bsctap_top
    import bsctap_pkg::*;
#(
    parameter int N_IN = bsctap_pkg::BSR_IN_DEFAULT, // sampled device inputs
    parameter int N_OUT = bsctap_pkg::BSR_OUT_DEFAULT, // driven device outputs
    parameter logic [31:0] ID_CODE = bsctap_pkg::ID_DEFAULT // arbitrary id value
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic test_port_reset_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [N_IN-1:0] core_in,
    input wire logic [N_OUT-1:0] core_out,
    output logic [N_OUT-1:0] pin_out,
    output logic test_mode
);
    import bsctap_pkg::*;

    localparam int BSR_LEN = N_IN + N_OUT; // chain length, outputs in high bits

    // ****************************************
    // elaboration checks
    // ****************************************
    if (N_IN < 1 || N_OUT < 1) begin : g_bad_size
        $error("boundary chain needs at least one input and one output");
    end
    if (BSR_LEN < ID_WIDTH) begin : g_bad_len
        $error("boundary chain shorter than identification code");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    bsctap_pins_s pins_async; // raw scan pins
    bsctap_pins_s pins; // synced scan pins
    bsctap_edge_s edges; // tck edge events
    logic [SYNC_STAGES-1:0] trst_sync; // reset release synchroniser
    wire logic tap_rst_n; // combined internal reset

    assign pins_async = '{tck: tck, tms: tms, tdi: tdi};
    assign tap_rst_n = rstn & test_port_reset_n;

    bsctap_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .pins_async(pins_async),
        .pins(pins),
        .edges(edges)
    );

    // async reset entry
    // assert at once, release through two flops
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            trst_sync <= '0;
        end else begin
            trst_sync <= {trst_sync[0], 1'b1};
        end
    end

    wire logic ctl_rst_n; // reset for the test logic except the pin synchronisers, which take rstn only
    assign ctl_rst_n = trst_sync[SYNC_STAGES-1] & tap_rst_n;

    // ****************************************
    // controller
    // ****************************************
    bsctap_state_e state; // current controller state

    bsctap_fsm u_fsm (
        .clk(clk),
        .rstn(ctl_rst_n),
        .tck_rise(edges.rise),
        .tms(pins.tms),
        .state(state)
    );

    // ****************************************
    // instruction decode
    // ****************************************
    logic [IR_WIDTH-1:0] ir_shift; // instruction shift stage
    logic [IR_WIDTH-1:0] ir; // current instruction
    wire logic sel_bsr; // boundary chain selected
    wire logic sel_id; // id register selected
    wire logic sel_byp; // bypass selected
    wire logic is_extest; // outputs forced from latch

    assign sel_bsr = (ir == INSN_EXTEST) || (ir == INSN_SAMPLE) || (ir == INSN_SCPT);
    assign sel_id = (ir == INSN_IDCODE);
    assign sel_byp = !sel_bsr && !sel_id;
    assign is_extest = (ir == INSN_EXTEST);

    // state strobes on tck edges
    wire logic cap_dr = edges.rise && state == ST_CAP_DR; // capture-dr edge
    wire logic sh_dr = edges.rise && state == ST_SHIFT_DR; // shift-dr edge
    wire logic upd_dr = edges.fall && state == ST_UPD_DR; // update-dr edge
    wire logic cap_ir = edges.rise && state == ST_CAP_IR; // capture-ir edge
    wire logic sh_ir = edges.rise && state == ST_SHIFT_IR; // shift-ir edge
    wire logic upd_ir = edges.fall && state == ST_UPD_IR; // update-ir edge

    // ****************************************
    // instruction register
    // ****************************************
    // capture and shift stage
    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            ir_shift <= IR_RESET;
        end else if (cap_ir) begin
            ir_shift <= IR_CAPTURE;
        end else if (sh_ir) begin
            ir_shift <= {pins.tdi, ir_shift[IR_WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            ir <= IR_RESET;
        end else if (state == ST_RESET) begin
            ir <= IR_RESET;
        end else if (upd_ir) begin
            ir <= ir_shift;
        end
    end

    // ****************************************
    // data registers
    // ****************************************
    logic byp; // single bypass stage
    logic [ID_WIDTH-1:0] id_sr; // id shift register
    logic [BSR_LEN-1:0] bsr; // boundary shift chain
    logic [N_OUT-1:0] bsr_latch; // boundary output latch
    wire logic [BSR_LEN-1:0] bsr_cap; // boundary capture value
    wire logic [BSR_LEN-1:0] id_wide; // id padded to chain length

    assign id_wide = BSR_LEN'(ID_CODE);

    assign bsr_cap = (ir == INSN_SCPT) ? id_wide : {core_out, core_in};

    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            byp <= 1'b0;
        end else if (cap_dr && sel_byp) begin
            byp <= 1'b0;
        end else if ((sh_dr && sel_byp) || sh_ir) begin
            byp <= pins.tdi;
        end
    end

    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            id_sr <= '0;
        end else if (cap_dr && sel_id) begin
            id_sr <= ID_CODE;
        end else if (sh_dr && sel_id) begin
            id_sr <= {pins.tdi, id_sr[ID_WIDTH-1:1]};
        end
    end

    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            bsr <= '0;
        end else if (cap_dr && sel_bsr) begin
            bsr <= bsr_cap;
        end else if (sh_dr && sel_bsr) begin
            bsr <= {pins.tdi, bsr[BSR_LEN-1:1]};
        end
    end

    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            bsr_latch <= '0;
        end else if (upd_dr && sel_bsr) begin
            bsr_latch <= bsr[BSR_LEN-1:N_IN];
        end
    end

    // ****************************************
    // pin muxing and tdo
    // ****************************************
    wire logic next_tdo; // serial output candidate
    wire logic [N_OUT-1:0] next_pin_out; // device output candidate

    assign next_tdo = (state == ST_SHIFT_IR) ? ir_shift[0] :
                      sel_bsr ? bsr[0] :
                      sel_id ? id_sr[0] : byp;
    assign next_pin_out = is_extest ? bsr_latch : core_out;

    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (edges.fall) begin
            tdo <= next_tdo;
            tdo_oe <= (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
        end
    end

    // device output register
    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            pin_out <= '0;
            test_mode <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            test_mode <= is_extest;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    logic [2:0] tms_hi_cnt; // count of tms high rises
    always_ff @(posedge clk or negedge ctl_rst_n) begin
        if (!ctl_rst_n) begin
            tms_hi_cnt <= '0;
        end else if (edges.rise) begin
            tms_hi_cnt <= pins.tms ? ((tms_hi_cnt == 3'h5) ? 3'h5 : tms_hi_cnt + 3'h1) : 3'h0;
        end
    end

    a_tms_five_reset: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (tms_hi_cnt == 3'h5) |-> (state == ST_RESET))
        else $error("five tms high edges did not reach reset");

    a_reset_idcode: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (state == ST_RESET) |=> (ir == INSN_IDCODE))
        else $error("reset state lost identification instruction");

    a_func_mode: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (state == ST_RESET) [*2] |=> (pin_out == $past(core_out)) && !test_mode)
        else $error("outputs not functional in reset state");

    a_shift_bsr: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (sh_dr && sel_bsr) |=> (bsr[BSR_LEN-2:0] == $past(bsr[BSR_LEN-1:1])))
        else $error("boundary chain did not shift toward lsb");

    a_upd_fall: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        !upd_dr |=> $stable(bsr_latch))
        else $error("output latch changed outside update-dr fall");

    a_cap_ir_fix: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        cap_ir |=> (ir_shift == IR_CAPTURE))
        else $error("capture-ir did not load fixed pattern");

    a_upd_ir_load: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        upd_ir |=> (ir == $past(ir_shift)))
        else $error("update-ir did not adopt shifted instruction");

    a_pause_hold: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (state == ST_PAUSE_DR) && $past(state == ST_PAUSE_DR) |-> $stable(bsr) && $stable(id_sr))
        else $error("data registers moved while paused");

    a_bypass_delay: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (sh_dr && sel_byp) |=> (byp == $past(pins.tdi)))
        else $error("bypass stage did not take tdi");

    a_scpt_capture: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (cap_dr && ir == INSN_SCPT) |=> (bsr == id_wide))
        else $error("production test capture missed id code");

    a_tdo_enable: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        edges.fall && state != ST_SHIFT_DR && state != ST_SHIFT_IR |=> !tdo_oe)
        else $error("tdo driven outside shift states");

    a_trst_entry: assert property (
        @(posedge clk) disable iff (!rstn)
        !test_port_reset_n |-> (state == ST_RESET) && !tdo_oe && !test_mode)
        else $error("test reset did not force reset state");

    a_cap_bsr_pins: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (cap_dr && sel_bsr && ir != INSN_SCPT) |=> (bsr == {$past(core_out), $past(core_in)}))
        else $error("capture-dr missed device pins");

    a_cap_id_load: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (cap_dr && sel_id) |=> (id_sr == ID_CODE))
        else $error("capture-dr missed identification code");

    a_shift_ir: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        sh_ir |=> (ir_shift == {$past(pins.tdi), $past(ir_shift[IR_WIDTH-1:1])}))
        else $error("instruction stage did not shift toward lsb");

    a_extest_drive: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        (ir == INSN_EXTEST) |=> (pin_out == $past(bsr_latch)) && test_mode)
        else $error("extest outputs not driven from latch");

    a_tdo_fall_only: assert property (
        @(posedge clk) disable iff (!ctl_rst_n)
        !edges.fall |=> $stable(tdo) && $stable(tdo_oe))
        else $error("tdo changed without a tck fall");

endmodule : bsctap_top
